//--- src/seq_irq_pkg.sv
package seq_irq_pkg;
  // Register word addresses (byte address = word index * 4)
  localparam logic [3:0] ADDR_SECOND_MODE = 4'h0; // Second mode register: edge selects
  localparam logic [3:0] ADDR_FIRST_MODE = 4'h1; // First mode register: enable bits
  localparam logic [3:0] ADDR_LATCH = 4'h2; // Interrupt latch register
  localparam logic [3:0] ADDR_MASK = 4'h3; // Interrupt mask register
  localparam logic [3:0] ADDR_SERVICE = 4'h4; // Current vector / service state
  localparam logic [3:0] ADDR_RETURN = 4'h5; // Write: return from interrupt
  localparam logic [3:0] ADDR_PC_SP = 4'h6; // Program-counter stack pointer
  localparam logic [3:0] ADDR_STACK_STAT = 4'h7; // Stack flags, write-one-to-clear overflow
  localparam logic [3:0] ADDR_LOOP_SP = 4'h8; // Loop stack pointer
  localparam logic [3:0] ADDR_STAT_SP = 4'h9; // Status stack pointer
  // Priority positions in the 64-bit latch
  localparam int POS_STACK = 3;
  localparam int POS_EXT0 = 8;
  localparam int POS_SOFT0 = 38;
  localparam int NUM_EXT = 3;
  localparam int NUM_SOFT = 4;
  localparam int NUM_POS = 64;
  // Latency figures in core cycles
  localparam int MODE_WRITE_LAT = 2; // Mode enable takes effect two cycles after write
  localparam int BRANCH_CYCLES = 4; // Branch cycles after recognition
  // Field positions in the stack status word
  localparam int STAT_EMPTY_LSB = 0; // PC, loop, status empty flags: bits 2..0
  localparam int STAT_FULL_LSB = 4; // Full flags: bits 6..4
  localparam int STAT_OVF_LSB = 8; // Overflow flags: bits 10..8
  // Service states
  typedef enum logic [1:0] {SVC_IDLE, SVC_RECOG, SVC_BRANCH, SVC_ACTIVE} svc_type;
endpackage : seq_irq_pkg

//--- src/sequencer_interrupt_sources.sv
// What this block does
// - Level mode: low sample registers a request
// - Still-low level line after return re-enters
// - Edge mode: high then low sample requests
// - Held-low edge line raises nothing more
// - Second mode bits 0-2 choose edge
// - Asynchronous request lines accepted, synchronised
// - External lines at positions 8 to 10
// - Latch holds four software interrupt bits
// - Software interrupts at positions 38 to 41
// - Recognised next cycle, four branch cycles
// - Software interrupts latch and mask normally
// - Any stack overflow raises position 3
// - Stack empty flags readable by software
// - Mask check, vector for highest unmasked
// - PC stack pointer write pushes or pops
// - Mode enable two cycles late, read lags
//
// The implementer's own choices: the Avalon-MM slave port and the register offsets.
`timescale 1ns/1ps
module sequencer_interrupt_sources #(
  parameter int STACK_DEPTH = 30, // PC stack entries
  parameter int LOOP_DEPTH = 6, // Loop stack entries
  parameter int STAT_DEPTH = 15 // Status stack entries
) (
  input wire logic i_clk,
  input wire logic i_srst,
  input wire logic [2:0] i_ext_request_lines_n, // Active-low request lines, asynchronous
  input wire logic i_loop_push, // Loop stack push from sequencer
  input wire logic i_loop_pop, // Loop stack pop from sequencer
  input wire logic i_stat_push, // Status stack push from sequencer
  input wire logic i_stat_pop, // Status stack pop from sequencer
  input wire logic [3:0] i_avs_address, // Word address
  input wire logic i_avs_read,
  input wire logic i_avs_write,
  input wire logic [31:0] i_avs_writedata,
  output logic [31:0] o_avs_readdata,
  output logic o_avs_waitrequest,
  output logic o_vector_valid, // Vector entered, service running
  output logic [5:0] o_vector_pos, // Position of serviced interrupt
  output logic [31:0] o_first_mode // Effective first mode register
);
  // Sampling enable: half the core rate
  logic half_en_r;
  // Synchroniser stages and previous sample
  logic [2:0] sync1_r, sync2_r, prev_r;
  // Registers
  logic [2:0] edge_sel_r; // Second mode edge selects
  logic [31:0] first_mode_register_wr_r, first_mode_register_d1_r, first_mode_register_eff_r;
  logic [63:0] latch_r, mask_r;
  logic [63:0] latch_nxt;
  logic [5:0] pc_sp_r, loop_sp_r, stat_sp_r;
  logic [2:0] ovf_r;
  // Service sequencer
  seq_irq_pkg::svc_type svc_r;
  logic [2:0] br_cnt_r;
  logic [5:0] pos_r;
  logic vec_valid_r; // Service running, kept in a flop so the output has no decode glitch
  // Bus handshake: one wait cycle then answer
  logic ack_r;
  logic waitreq_r; // Registered wait, low only in the answer cycle
  logic [31:0] rdata_r;

  // Returns index of lowest set bit
  function automatic logic [5:0] lowest_set(input logic [63:0] v);
    lowest_set = 6'h00;
    for (int i = seq_irq_pkg::NUM_POS - 1; i >= 0; i--)
    begin
      if (v[i])
        lowest_set = 6'(i);
    end
  endfunction : lowest_set

  // Bus decode
  wire logic req = (i_avs_read | i_avs_write) & ~ack_r;
  wire logic wr_go = i_avs_write & ack_r;
  wire logic wr_second_mode_register = wr_go && i_avs_address == seq_irq_pkg::ADDR_SECOND_MODE;
  wire logic wr_first_mode_register = wr_go && i_avs_address == seq_irq_pkg::ADDR_FIRST_MODE;
  wire logic wr_latch = wr_go && i_avs_address == seq_irq_pkg::ADDR_LATCH;
  wire logic wr_mask = wr_go && i_avs_address == seq_irq_pkg::ADDR_MASK;
  wire logic wr_ret = wr_go && i_avs_address == seq_irq_pkg::ADDR_RETURN;
  wire logic wr_pcsp = wr_go && i_avs_address == seq_irq_pkg::ADDR_PC_SP;
  wire logic wr_stat = wr_go && i_avs_address == seq_irq_pkg::ADDR_STACK_STAT;

  // Detection on synchronised samples
  wire logic [2:0] level_hit = ~sync2_r & ~edge_sel_r;
  wire logic [2:0] edge_hit = prev_r & ~sync2_r & edge_sel_r;
  wire logic [2:0] ext_hit = half_en_r ? (level_hit | edge_hit) : 3'h0;

  // Stack flags
  wire logic [2:0] empty_f = {stat_sp_r == 6'h00, loop_sp_r == 6'h00, pc_sp_r == 6'h00};
  wire logic [2:0] full_f = {stat_sp_r == 6'(STAT_DEPTH), loop_sp_r == 6'(LOOP_DEPTH),
                             pc_sp_r == 6'(STACK_DEPTH)};
  wire logic pc_push = wr_pcsp && i_avs_writedata[5:0] > pc_sp_r;
  wire logic [2:0] ovf_ev = {i_stat_push & full_f[2], i_loop_push & full_f[1], pc_push & full_f[0]};

  // Highest-priority unmasked pending request
  wire logic [63:0] pending = latch_r & mask_r;
  wire logic [5:0] win_pos = lowest_set(pending);

  // Stored service state word
  wire logic [31:0] svc_word = {22'h0, 2'(svc_r), 2'h0, pos_r};
  wire logic [31:0] stat_word = {21'h0, ovf_r, 1'b0, full_f, 1'b0, empty_f};

  // Half-rate sample enable
  always_ff @(posedge i_clk)
  begin
    if (i_srst)
      half_en_r <= 1'b0;
    else
      half_en_r <= ~half_en_r;
  end

  // Two-stage synchroniser then previous sample for edges
  always_ff @(posedge i_clk)
  begin
    if (i_srst)
    begin
      sync1_r <= 3'h7;
      sync2_r <= 3'h7;
      prev_r <= 3'h7;
    end
    else if (half_en_r)
    begin
      sync1_r <= i_ext_request_lines_n;
      sync2_r <= sync1_r;
      prev_r <= sync2_r;
    end
  end

  // Mode registers; first mode delayed so new enables act two cycles later
  always_ff @(posedge i_clk)
  begin
    if (i_srst)
    begin
      edge_sel_r <= 3'h0;
      first_mode_register_wr_r <= 32'h00000000;
      first_mode_register_d1_r <= 32'h00000000;
      first_mode_register_eff_r <= 32'h00000000;
    end
    else
    begin
      if (wr_second_mode_register)
        edge_sel_r <= i_avs_writedata[2:0];
      if (wr_first_mode_register)
        first_mode_register_wr_r <= i_avs_writedata;
      first_mode_register_d1_r <= first_mode_register_wr_r;
      first_mode_register_eff_r <= first_mode_register_d1_r;
    end
  end

  // Latch: software write, events set; events win over the clear on entry
  always_comb
  begin
    latch_nxt = latch_r;
    if (wr_latch)
      latch_nxt = i_avs_writedata[31:0] == 32'h0 ? {latch_r[63:32], 32'h0} : latch_r;
    if (svc_r == seq_irq_pkg::SVC_RECOG)
      latch_nxt[pos_r] = 1'b0;
    latch_nxt[seq_irq_pkg::POS_EXT0 +: seq_irq_pkg::NUM_EXT] =
      latch_nxt[seq_irq_pkg::POS_EXT0 +: seq_irq_pkg::NUM_EXT] | ext_hit;
    if (|ovf_ev)
      latch_nxt[seq_irq_pkg::POS_STACK] = 1'b1;
  end

  // Latch and mask registers; latch write sets software bits 38 to 41 from data bits 3..0
  always_ff @(posedge i_clk)
  begin
    if (i_srst)
    begin
      latch_r <= 64'h0;
      mask_r <= 64'h0;
    end
    else
    begin
      latch_r <= latch_nxt;
      if (wr_latch)
        latch_r[seq_irq_pkg::POS_SOFT0 +: seq_irq_pkg::NUM_SOFT] <=
          latch_nxt[seq_irq_pkg::POS_SOFT0 +: seq_irq_pkg::NUM_SOFT] | i_avs_writedata[3:0];
      if (wr_mask)
        mask_r <= {i_avs_writedata, i_avs_writedata};
    end
  end

  // Service sequencer: recognise, branch four cycles, run until return
  always_ff @(posedge i_clk)
  begin
    if (i_srst)
    begin
      svc_r <= seq_irq_pkg::SVC_IDLE;
      br_cnt_r <= 3'h0;
      pos_r <= 6'h00;
      vec_valid_r <= 1'b0;
    end
    else
    begin
      case (svc_r)
        seq_irq_pkg::SVC_IDLE:
        begin
          if (|pending)
          begin
            svc_r <= seq_irq_pkg::SVC_RECOG;
            pos_r <= win_pos;
          end
        end
        seq_irq_pkg::SVC_RECOG:
        begin
          svc_r <= seq_irq_pkg::SVC_BRANCH;
          br_cnt_r <= 3'(seq_irq_pkg::BRANCH_CYCLES - 1);
        end
        seq_irq_pkg::SVC_BRANCH:
        begin
          if (br_cnt_r == 3'h0)
          begin
            svc_r <= seq_irq_pkg::SVC_ACTIVE;
            vec_valid_r <= 1'b1;
          end
          else
            br_cnt_r <= br_cnt_r - 3'h1;
        end
        seq_irq_pkg::SVC_ACTIVE:
        begin
          if (wr_ret)
          begin
            svc_r <= seq_irq_pkg::SVC_IDLE;
            vec_valid_r <= 1'b0;
          end
        end
        default:
          svc_r <= seq_irq_pkg::SVC_IDLE;
      endcase
    end
  end

  // Stack pointers and sticky overflow flags
  always_ff @(posedge i_clk)
  begin
    if (i_srst)
    begin
      pc_sp_r <= 6'h00;
      loop_sp_r <= 6'h00;
      stat_sp_r <= 6'h00;
      ovf_r <= 3'h0;
    end
    else
    begin
      if (wr_pcsp && !(pc_push && full_f[0]))
        pc_sp_r <= i_avs_writedata[5:0];
      if (i_loop_push && !full_f[1])
        loop_sp_r <= loop_sp_r + 6'h01;
      else if (i_loop_pop && !empty_f[1])
        loop_sp_r <= loop_sp_r - 6'h01;
      if (i_stat_push && !full_f[2])
        stat_sp_r <= stat_sp_r + 6'h01;
      else if (i_stat_pop && !empty_f[2])
        stat_sp_r <= stat_sp_r - 6'h01;
      // Set wins over write-one-to-clear
      ovf_r <= (ovf_r & ~(wr_stat ? i_avs_writedata[seq_irq_pkg::STAT_OVF_LSB +: 3] : 3'h0)) | ovf_ev;
    end
  end

  // Read mux
  logic [31:0] rmux;
  always_comb
  begin
    case (i_avs_address)
      seq_irq_pkg::ADDR_SECOND_MODE: rmux = {29'h0, edge_sel_r};
      seq_irq_pkg::ADDR_FIRST_MODE: rmux = first_mode_register_d1_r;
      seq_irq_pkg::ADDR_LATCH: rmux = latch_r[31:0] | {latch_r[63:32] != 32'h0, 31'h0};
      seq_irq_pkg::ADDR_MASK: rmux = mask_r[31:0];
      seq_irq_pkg::ADDR_SERVICE: rmux = svc_word;
      seq_irq_pkg::ADDR_PC_SP: rmux = {26'h0, pc_sp_r};
      seq_irq_pkg::ADDR_STACK_STAT: rmux = stat_word;
      seq_irq_pkg::ADDR_LOOP_SP: rmux = {26'h0, loop_sp_r};
      seq_irq_pkg::ADDR_STAT_SP: rmux = {26'h0, stat_sp_r};
      default: rmux = 32'h00000000;
    endcase
  end

  // Bus answer: waitrequest low one cycle after request
  always_ff @(posedge i_clk)
  begin
    if (i_srst)
    begin
      ack_r <= 1'b0;
      waitreq_r <= 1'b1;
      rdata_r <= 32'h0;
    end
    else
    begin
      ack_r <= req;
      waitreq_r <= ~req; // Mirrors the acknowledge, inverted
      if (req && i_avs_read)
        rdata_r <= rmux;
    end
  end

  // Outputs
  assign o_avs_waitrequest = waitreq_r;
  assign o_avs_readdata = rdata_r;
  assign o_vector_valid = vec_valid_r;
  assign o_vector_pos = pos_r;
  assign o_first_mode = first_mode_register_eff_r;

  // Assertions
  chk_edge_needs_high: assert property (@(posedge i_clk) disable iff (i_srst)
    (half_en_r && edge_sel_r[1] && !prev_r[1]) |=> !latch_r[seq_irq_pkg::POS_EXT0 + 1] ||
      $past(latch_r[seq_irq_pkg::POS_EXT0 + 1])) else $error("edge request without high sample");
  chk_level_latch: assert property (@(posedge i_clk) disable iff (i_srst)
    (half_en_r && !edge_sel_r[0] && !sync2_r[0]) |=> latch_r[seq_irq_pkg::POS_EXT0])
    else $error("level request not latched");
  chk_branch_four: assert property (@(posedge i_clk) disable iff (i_srst)
    (svc_r == seq_irq_pkg::SVC_RECOG) |=> (svc_r == seq_irq_pkg::SVC_BRANCH) [*4] ##1
      (svc_r == seq_irq_pkg::SVC_ACTIVE)) else $error("branch not four cycles");
  chk_recog_next: assert property (@(posedge i_clk) disable iff (i_srst)
    (svc_r == seq_irq_pkg::SVC_IDLE && |pending) |=> svc_r == seq_irq_pkg::SVC_RECOG)
    else $error("recognition late");
  chk_lowest_first: assert property (@(posedge i_clk) disable iff (i_srst)
    (svc_r == seq_irq_pkg::SVC_IDLE && |pending) |=> pos_r == $past(win_pos))
    else $error("wrong priority chosen");
  chk_mode_lat: assert property (@(posedge i_clk) disable iff (i_srst)
    wr_first_mode_register |-> ##3 o_first_mode == $past(i_avs_writedata, 3)) else $error("mode latency wrong");
  chk_overflow_irq: assert property (@(posedge i_clk) disable iff (i_srst)
    (|ovf_ev) |=> latch_r[seq_irq_pkg::POS_STACK] && ovf_r != 3'h0) else $error("overflow lost");
  chk_entry_clears: assert property (@(posedge i_clk) disable iff (i_srst)
    (svc_r == seq_irq_pkg::SVC_RECOG && pos_r == 6'(seq_irq_pkg::POS_SOFT0)) |=>
      !latch_r[seq_irq_pkg::POS_SOFT0]) else $error("latch not cleared on entry");
endmodule : sequencer_interrupt_sources

//--- test/irq_line_model.sv
`timescale 1ns/1ps
// Outside devices on the three active-low request lines
module irq_line_model (
  input wire logic i_clk,
  input wire logic [2:0] i_assert,
  output logic [2:0] o_lines_n
);
  // Lines are high (inactive) until a device asks; a level source lets go only
  // when told, so the bench decides whether it releases before the return
  // Retimed to the core clock, but the block must still treat them as unrelated
  always_ff @(posedge i_clk)
  begin
    o_lines_n <= ~i_assert;
  end
endmodule : irq_line_model

//--- test/testbench.sv
`timescale 1ns/1ps
module testbench;
  logic i_clk = 1'b0; // Core clock
  logic i_srst = 1'b1; // Reset, held at start
  logic [2:0] line_on = 3'h0; // Lines the devices pull low
  logic [2:0] lines_n; // Request lines
  logic i_loop_push = 1'b0; // Loop stack push pulse
  logic i_loop_pop = 1'b0; // Loop stack pop pulse
  logic i_stat_push = 1'b0; // Status stack push pulse
  logic i_stat_pop = 1'b0; // Status stack pop pulse
  logic [3:0] addr = 4'h0; // Bus address
  logic rd = 1'b0; // Bus read strobe
  logic wr = 1'b0; // Bus write strobe
  logic [31:0] wdata = 32'h0; // Bus write data
  logic [31:0] rdata; // Bus read data
  logic wait_r; // Bus wait
  logic vec_valid; // Service running
  logic prev_vec = 1'b0; // Last sample of vec_valid
  logic [5:0] vec_pos; // Serviced position
  logic [31:0] first_mode; // Effective first mode
  logic [31:0] rd_q[$]; // Expected read data
  logic [5:0] vec_q[$]; // Expected vector positions
  logic [31:0] rnd; // Random mode value
  int error_cnt = 0;
  int cmp_count = 0;
  int cycles = 0; // Timeout counter
  int seed = 91740;
  irq_line_model dev (.i_clk(i_clk), .i_assert(line_on), .o_lines_n(lines_n));
  // All stack movement strobes come from the bench
  sequencer_interrupt_sources uut (.i_clk(i_clk), .i_srst(i_srst), .i_ext_request_lines_n(lines_n),
    .i_loop_push(i_loop_push), .i_loop_pop(i_loop_pop), .i_stat_push(i_stat_push), .i_stat_pop(i_stat_pop),
    .i_avs_address(addr), .i_avs_read(rd), .i_avs_write(wr), .i_avs_writedata(wdata),
    .o_avs_readdata(rdata), .o_avs_waitrequest(wait_r), .o_vector_valid(vec_valid),
    .o_vector_pos(vec_pos), .o_first_mode(first_mode));
  // Clock at 100 ns period
  initial
  begin
    forever #50 i_clk = ~i_clk;
  end
  task stop_test;
    if (error_cnt == 0 && cmp_count > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : stop_test
  task fail(input string msg);
    error_cnt++;
    $display("[FAIL] %0t %s", $time, msg);
  endtask : fail
  task cmp32(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp)
      fail($sformatf("word %h expected %h", got, exp));
  endtask : cmp32
  task cmp6(input logic [5:0] got, input logic [5:0] exp);
    cmp_count++;
    if (got !== exp)
      fail($sformatf("vector %0d expected %0d", got, exp));
  endtask : cmp6
  // One Avalon access; held until waitrequest is sampled low, then released
  task bus(input logic w, input logic [3:0] a, input logic [31:0] d);
    rd <= !w;
    wr <= w;
    addr <= a;
    wdata <= d;
    @(posedge i_clk);
    while (wait_r !== 1'b0)
      @(posedge i_clk);
    rd <= 1'b0;
    wr <= 1'b0;
    @(posedge i_clk);
  endtask : bus
  task rd_chk(input logic [3:0] a, input logic [31:0] exp);
    rd_q.push_back(exp);
    bus(1'b0, a, 32'h0);
  endtask : rd_chk
  // Wait for a vector, let chosen lines go, clear low latches, then return
  task serve(input logic [2:0] rel);
    int n;
    n = 0;
    while (vec_valid !== 1'b1 && n < 100)
    begin
      @(posedge i_clk);
      n++;
    end
    if (n == 100)
      fail("no vector");
    line_on <= line_on & ~rel;
    repeat (10) @(posedge i_clk);
    bus(1'b1, seq_irq_pkg::ADDR_LATCH, 32'h0);
    bus(1'b1, seq_irq_pkg::ADDR_RETURN, 32'h0);
  endtask : serve
  // Watcher: compares each answered read and each vector entry to the oldest note
  always @(posedge i_clk)
  begin
    if (rd && wait_r === 1'b0)
      if (rd_q.size() == 0) fail("read not expected");
      else cmp32(rdata, rd_q.pop_front());
    if (vec_valid === 1'b1 && prev_vec !== 1'b1)
      if (vec_q.size() == 0) fail("vector not expected");
      else cmp6(vec_pos, vec_q.pop_front());
    prev_vec <= vec_valid;
  end
  // Hang guard: the sequence needs a few hundred cycles
  always @(posedge i_clk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      fail("timeout");
      stop_test();
    end
  end
  // Main sequence
  initial
  begin
    repeat (6) @(posedge i_clk);
    i_srst <= 1'b0;
    @(posedge i_clk);
    rd_chk(seq_irq_pkg::ADDR_LATCH, 32'h0);
    rd_chk(seq_irq_pkg::ADDR_SECOND_MODE, 32'h0);
    rd_chk(seq_irq_pkg::ADDR_STACK_STAT, 32'h7);
    rd_chk(4'hc, 32'h0);
    rnd = $random(seed);
    bus(1'b1, seq_irq_pkg::ADDR_FIRST_MODE, rnd);
    repeat (2) @(posedge i_clk);
    cmp32(first_mode, rnd);
    rd_chk(seq_irq_pkg::ADDR_FIRST_MODE, rnd);
    // Two soft requests while all masked, then unmask: lower position first
    bus(1'b1, seq_irq_pkg::ADDR_LATCH, 32'ha);
    rd_chk(seq_irq_pkg::ADDR_LATCH, 32'h80000000);
    vec_q.push_back(6'd39);
    vec_q.push_back(6'd41);
    bus(1'b1, seq_irq_pkg::ADDR_MASK, 32'hffffffff);
    serve(3'h0);
    serve(3'h0);
    for (int k = 0; k < 4; k++)
    begin
      vec_q.push_back(6'(seq_irq_pkg::POS_SOFT0 + k));
      bus(1'b1, seq_irq_pkg::ADDR_LATCH, 32'h1 << k);
      serve(3'h0);
    end
    vec_q.push_back(6'd8);
    line_on <= 3'h1;
    serve(3'h1);
    vec_q.push_back(6'd10);
    vec_q.push_back(6'd10);
    line_on <= 3'h4;
    serve(3'h0);
    serve(3'h4);
    // Edge mode: a held-low line gives one request only
    bus(1'b1, seq_irq_pkg::ADDR_SECOND_MODE, 32'h7);
    vec_q.push_back(6'd9);
    line_on <= 3'h2;
    serve(3'h0);
    repeat (40) @(posedge i_clk);
    line_on <= 3'h0;
    repeat (10) @(posedge i_clk);
    vec_q.push_back(6'd9);
    line_on <= 3'h2;
    serve(3'h2);
    bus(1'b1, seq_irq_pkg::ADDR_PC_SP, 32'h1);
    rd_chk(seq_irq_pkg::ADDR_PC_SP, 32'h1);
    rd_chk(seq_irq_pkg::ADDR_STACK_STAT, 32'h6);
    bus(1'b1, seq_irq_pkg::ADDR_PC_SP, 32'h0);
    rd_chk(seq_irq_pkg::ADDR_STACK_STAT, 32'h7);
    // Seven pushes into a six-deep loop stack overflow it
    vec_q.push_back(6'(seq_irq_pkg::POS_STACK));
    repeat (7)
    begin
      i_loop_push <= 1'b1;
      @(posedge i_clk);
      i_loop_push <= 1'b0;
      @(posedge i_clk);
    end
    serve(3'h0);
    rd_chk(seq_irq_pkg::ADDR_STACK_STAT, 32'h225);
    rd_chk(seq_irq_pkg::ADDR_LOOP_SP, 32'h6);
    // Status pushes with loop pops, then push and pop together: push wins
    i_stat_push <= 1'b1;
    i_loop_pop <= 1'b1;
    repeat (3) @(posedge i_clk);
    i_stat_pop <= 1'b1;
    @(posedge i_clk);
    i_stat_push <= 1'b0;
    i_loop_pop <= 1'b0;
    @(posedge i_clk);
    i_stat_pop <= 1'b0;
    rd_chk(seq_irq_pkg::ADDR_STAT_SP, 32'h3);
    rd_chk(seq_irq_pkg::ADDR_LOOP_SP, 32'h2);
    // Overflow flag serves only as a diagnostic; software clears it by writing one
    bus(1'b1, seq_irq_pkg::ADDR_STACK_STAT, 32'h200);
    rd_chk(seq_irq_pkg::ADDR_STACK_STAT, 32'h1);
    if (rd_q.size() != 0 || vec_q.size() != 0)
      fail("expected results left over");
    stop_test();
  end
endmodule : testbench
